// ==== rtl/cal_ctrl_defs.vh ====
// Constants for the converter calibration and control block.
// Assumes a single 50 MHz clock; included by bare name.
`ifndef CAL_CTRL_DEFS_VH
`define CAL_CTRL_DEFS_VH
// Register byte offsets
`define OFF_CTRL 4'h0
`define OFF_STAT 4'h4
`define OFF_SAMP 4'h8
`define OFF_CAPT 4'hc
// Control register field positions
`define CTRL_CAL_REQ 0
`define CTRL_PDOWN 1
`define CTRL_DLY_SEL 2
`define CTRL_EXT_MODE 3
`define CTRL_REG_DLY 4
`define CTRL_PHASE_EN 5
`define CTRL_RTD 6
`define CTRL_FSR 7
`define CTRL_OER 8
`define CTRL_RESET 9'h000
// Command phase length in input clock cycles
`define CMD_CYCLES 80
// Power-up delay exponents
`define DLY_SHORT_EXP 25
`define DLY_LONG_EXP 31
// Calibration run length default in cycles
`define CAL_LEN 1024
// Offset-binary range limits
`define CODE_MIN 8'h00
`define CODE_MAX 8'hff
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== rtl/cal_ctrl.v ====
// Calibration sequencing, out-of-range coding and capture-start control
// for a dual-interleaved 8-bit converter, with an AXI4-Lite register slave.
// Assumes AXI master and sample inputs share mclk; pins except the extended mode strap are synchronised.
//
// Operation
// R1: Clamp codes to all-zero or all-one out-of-range
// R2: Single out-of-range flag for either excursion
// R3: Calibrate after power-up delay and on command
// R4: Command is 80 cycles low then 80 high
// R5: Request high at power-up waits for command
// R6: Delay counts 2^25 or 2^31 cycles by select
// R7: Power-down at power-up holds delay counter
// R8: Power-down waits for running calibration to finish
// R9: Commands ignored while powered down
// R10: Data and range flag invalid during calibration
// R11: Phase adjust stops clock unless trim disabled
// R12: Host runs one calibration with trim enabled
// R13: Host avoids register access during calibration
// R14: Running output high for whole calibration
// R15: Host recalibrates after full-scale select change
// R16: Host recalibrates twenty seconds after power-up
// R17: Capture starts after both converters finish cycle
// R18: Capture data on two 8-bit buses
// R19: Samples coded as offset binary
// R20: Sample on both clock edges continuously
// R21: Extended mode uses registers, not pins; power-down here ORs pin and register bit in both modes
// R22: Host never switches control mode during operation
// R23: Delay no longer than 2^25 or 2^31 cycles
// R24: Count consecutive low then high request cycles
`timescale 1ns/1ps
`default_nettype none
`include "cal_ctrl_defs.vh"
module cal_ctrl #(
  parameter [31:0] DLY_SHORT = 32'h0200_0000, // 2^25 cycles
  parameter [31:0] DLY_LONG = 32'h8000_0000, // 2^31 cycles
  parameter [15:0] CAL_CYCLES = `CAL_LEN // Calibration run length
) (
  input wire mclk,
  input wire rst_n,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire cal_request_pin,
  input wire power_down_input,
  input wire cal_delay_select,
  input wire full_scale_select,
  input wire output_edge_rate_select,
  input wire extended_mode_pin,
  input wire write_enable_pin,
  input wire [8:0] rise_sample,
  input wire [8:0] fall_sample,
  output reg calibration_running,
  output reg out_of_range,
  output reg [7:0] data_rise,
  output reg [7:0] data_fall,
  output reg capture_write,
  output reg powered_down,
  output reg internal_clock_stop,
  output reg full_scale_eff,
  output reg output_edge_eff
);
  // Calibration states
  localparam [1:0] ST_DELAY = 2'd0;
  localparam [1:0] ST_IDLE = 2'd1;
  localparam [1:0] ST_CAL = 2'd2;
  localparam [1:0] ST_PDOWN = 2'd3;

  // Two-stage synchronisers for all pins except the extended mode strap
  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;
  wire cal_pin = sync2_reg[0];
  wire pd_pin = sync2_reg[1];
  wire dly_pin = sync2_reg[2];
  wire fsr_pin = sync2_reg[3];
  wire oer_pin = sync2_reg[4];
  wire wen_pin = sync2_reg[5];
  reg ext_reg; // Extended mode, sampled through the power-up delay, then held
  reg [8:0] ctrl_reg; // Software control word
  reg [1:0] state_reg; // Calibration sequencer state
  reg [31:0] dly_cnt_reg; // Power-up delay counter
  reg [15:0] cal_cnt_reg; // Calibration run counter
  reg [6:0] low_cnt_reg; // Consecutive low cycles of request
  reg [6:0] high_cnt_reg; // Consecutive high cycles after low
  reg armed_reg; // Low phase complete
  reg [1:0] wen_ph_reg; // Converter phases seen since write request
  reg [15:0] cal_done_reg; // Completed calibration count

  // Pin synchronisation; first stage read only by the second
  always @(posedge mclk) begin
    if (!rst_n) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= {write_enable_pin, output_edge_rate_select, full_scale_select,
                    cal_delay_select, power_down_input, cal_request_pin};
      sync2_reg <= sync1_reg;
    end
  end

  // Effective controls: register bits override pins in extended mode, except power-down (pin OR bit) [R21]
  wire req_lvl = ext_reg ? ctrl_reg[`CTRL_CAL_REQ] : cal_pin;
  wire pd_lvl = pd_pin | ctrl_reg[`CTRL_PDOWN];
  wire dly_sel = ext_reg ? ctrl_reg[`CTRL_REG_DLY] : dly_pin; // [R21]
  wire [31:0] dly_target = dly_sel ? DLY_LONG : DLY_SHORT; // [R6] [R23]
  wire cmd_valid = armed_reg && req_lvl && (high_cnt_reg >= (`CMD_CYCLES - 1));

  // Command detector: consecutive low cycles then consecutive high cycles
  always @(posedge mclk) begin
    if (!rst_n) begin
      low_cnt_reg <= 7'h00;
      high_cnt_reg <= 7'h00;
      armed_reg <= 1'b0;
    end else if (state_reg == ST_PDOWN || pd_lvl) begin
      // Commands seen while powered down are discarded [R9]
      low_cnt_reg <= 7'h00;
      high_cnt_reg <= 7'h00;
      armed_reg <= 1'b0;
    end else if (!req_lvl) begin
      high_cnt_reg <= 7'h00; // High phase broken restarts it [R24]
      if (low_cnt_reg >= (`CMD_CYCLES - 1)) begin
        armed_reg <= 1'b1; // [R4]
      end else begin
        low_cnt_reg <= low_cnt_reg + 7'h01;
      end
    end else begin
      low_cnt_reg <= 7'h00; // Short low phase restarts count [R24]
      if (cmd_valid) begin
        armed_reg <= 1'b0; // Command consumed [R4]
        high_cnt_reg <= 7'h00;
      end else if (armed_reg) begin
        high_cnt_reg <= high_cnt_reg + 7'h01;
      end
    end
  end

  // Calibration sequencer
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= ST_DELAY;
      dly_cnt_reg <= 32'h0000_0000;
      cal_cnt_reg <= 16'h0000;
      cal_done_reg <= 16'h0000;
      ext_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_DELAY: begin
          ext_reg <= extended_mode_pin; // Strap caught after release
          if (pd_lvl) begin
            dly_cnt_reg <= dly_cnt_reg; // Counter held in power-down [R7]
          end else if (dly_cnt_reg >= dly_target - 32'h1) begin
            // Request high at power-up defers to a real command [R5]
            state_reg <= cal_pin ? ST_IDLE : ST_CAL; // [R3]
            cal_cnt_reg <= 16'h0000;
          end else begin
            dly_cnt_reg <= dly_cnt_reg + 32'h1; // [R6]
          end
        end
        ST_IDLE: begin
          if (pd_lvl) begin
            state_reg <= ST_PDOWN;
          end else if (cmd_valid) begin
            state_reg <= ST_CAL; // On-command calibration [R3]
            cal_cnt_reg <= 16'h0000;
          end
        end
        ST_CAL: begin
          // Power-down is honoured only after the run ends [R8]
          if (cal_cnt_reg >= CAL_CYCLES - 16'h1) begin
            state_reg <= pd_lvl ? ST_PDOWN : ST_IDLE;
            cal_done_reg <= cal_done_reg + 16'h1;
          end else begin
            cal_cnt_reg <= cal_cnt_reg + 16'h1;
          end
        end
        ST_PDOWN: begin
          if (!pd_lvl) begin
            state_reg <= ST_IDLE; // No calibration started by wake-up [R9]
          end
        end
        default: state_reg <= ST_DELAY;
      endcase
    end
  end

  // Range detection and offset-binary clamping of both converters
  wire rise_hi = rise_sample[8] & ~rise_sample[7];
  wire rise_lo = rise_sample[8] & rise_sample[7];
  wire fall_hi = fall_sample[8] & ~fall_sample[7];
  wire fall_lo = fall_sample[8] & fall_sample[7];
  wire cal_now = (state_reg == ST_CAL);
  // Sample bit 8 flags overflow, bit 7 then tells below (1) or above (0)

  // Output data path; both edge converters pass in parallel [R20] [R18]
  always @(posedge mclk) begin
    if (!rst_n) begin
      data_rise <= `CODE_MIN;
      data_fall <= `CODE_MIN;
      out_of_range <= 1'b0;
    end else begin
      // Offset binary clamps at the ends of the code range [R1] [R19]
      data_rise <= rise_lo ? `CODE_MIN : (rise_hi ? `CODE_MAX : rise_sample[7:0]);
      data_fall <= fall_lo ? `CODE_MIN : (fall_hi ? `CODE_MAX : fall_sample[7:0]);
      // One flag for any excursion; may toggle while calibrating [R2] [R10]
      out_of_range <= rise_sample[8] | fall_sample[8];
    end
  end

  // Capture start waits for a full cycle of both converters [R17]
  always @(posedge mclk) begin
    if (!rst_n) begin
      wen_ph_reg <= 2'h0;
      capture_write <= 1'b0;
    end else if (!wen_pin || pd_lvl || cal_now) begin
      wen_ph_reg <= 2'h0;
      capture_write <= 1'b0;
    end else if (wen_ph_reg == 2'h2) begin
      capture_write <= 1'b1;
    end else begin
      wen_ph_reg <= wen_ph_reg + 2'h1;
    end
  end

  // Status outputs
  always @(posedge mclk) begin
    if (!rst_n) begin
      calibration_running <= 1'b0;
      powered_down <= 1'b0;
      internal_clock_stop <= 1'b0;
      full_scale_eff <= 1'b0;
      output_edge_eff <= 1'b0;
    end else begin
      calibration_running <= cal_now; // Whole run, any cause [R14]
      powered_down <= (state_reg == ST_PDOWN);
      // Clock halts when phase adjust is on and trim is enabled [R11]
      internal_clock_stop <= cal_now & ctrl_reg[`CTRL_PHASE_EN] & ~ctrl_reg[`CTRL_RTD];
      full_scale_eff <= ext_reg ? ctrl_reg[`CTRL_FSR] : fsr_pin; // [R21]
      output_edge_eff <= ext_reg ? ctrl_reg[`CTRL_OER] : oer_pin; // [R21]
    end
  end

  // AXI4-Lite write channel: address and data taken in either order
  reg aw_hold_reg;
  reg w_hold_reg;
  reg [3:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_hold_reg | aw_take;
  wire w_have = w_hold_reg | w_take;
  wire [3:0] wa = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wd = w_hold_reg ? w_data_reg : s_axi_wdata;
  wire [3:0] ws = w_hold_reg ? w_strb_reg : s_axi_wstrb;
  wire do_write = aw_have & w_have & ~s_axi_bvalid;

  // Write handshake and control register update
  always @(posedge mclk) begin
    if (!rst_n) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      ctrl_reg <= `CTRL_RESET;
    end else begin
      s_axi_awready <= ~aw_have & ~s_axi_bvalid & ~s_axi_awready;
      s_axi_wready <= ~w_have & ~s_axi_bvalid & ~s_axi_wready;
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wa == `OFF_CTRL) begin
          s_axi_bresp <= `RESP_OKAY;
          if (ws[0]) ctrl_reg[7:0] <= wd[7:0];
          if (ws[1]) ctrl_reg[8] <= wd[8];
        end else if (wa == `OFF_STAT || wa == `OFF_SAMP || wa == `OFF_CAPT) begin
          s_axi_bresp <= `RESP_OKAY; // Read-only, write ignored
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel, one cycle after address taken
  always @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & ~s_axi_arvalid;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (s_axi_araddr)
          `OFF_CTRL: s_axi_rdata <= {23'h0, ctrl_reg};
          `OFF_STAT: s_axi_rdata <= {cal_done_reg, 9'h0, ext_reg, armed_reg,
                                     powered_down, calibration_running, 1'b0, state_reg};
          `OFF_SAMP: s_axi_rdata <= {15'h0, out_of_range, data_fall, data_rise};
          `OFF_CAPT: s_axi_rdata <= {30'h0, capture_write, wen_pin};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // cal_ctrl
`default_nettype wire

// ==== testbench/cal_ctrl_asserts.sv ====
// Port-level checks for the calibration control block.
// Assumes one clock, mclk, and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cal_ctrl_asserts #(
  parameter [15:0] CAL_CYCLES = 16'h0010
) (
  input wire mclk,
  input wire rst_n,
  input wire power_down_input,
  input wire write_enable_pin,
  input wire [8:0] rise_sample,
  input wire [8:0] fall_sample,
  input wire calibration_running,
  input wire out_of_range,
  input wire [7:0] data_rise,
  input wire [7:0] data_fall,
  input wire capture_write,
  input wire powered_down,
  input wire internal_clock_stop
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [15:0] run_cnt; // Cycles of the current calibration
  // Cleared between runs so each run is measured alone
  always @(posedge mclk) begin
    if (!rst_n || !calibration_running) run_cnt <= 16'h0000;
    else run_cnt <= run_cnt + 16'h0001;
  end
  // Samples held still, outside calibration, so latency of one or two cycles both pass
  sequence s_steady;
    !calibration_running && !powered_down && !$past(calibration_running, 2) && $past(rst_n, 2)
      && $past(rise_sample) == $past(rise_sample, 2) && $past(fall_sample) == $past(fall_sample, 2);
  endsequence
  sequence s_cal_end;
    calibration_running ##1 !calibration_running;
  endsequence
  a_range_flag: assert property (s_steady |->
    out_of_range == ($past(rise_sample[8]) | $past(fall_sample[8]))) else $error("range flag wrong");
  a_clamp_low: assert property (s_steady ##0 $past(rise_sample[8:7]) == 2'h3 |->
    data_rise == 8'h00) else $error("low clamp wrong");
  a_clamp_high: assert property (s_steady ##0 $past(fall_sample[8:7]) == 2'h2 |->
    data_fall == 8'hff) else $error("high clamp wrong");
  a_code_pass: assert property (s_steady ##0 !$past(rise_sample[8]) |->
    data_rise == $past(rise_sample[7:0])) else $error("code not passed");
  a_run_length: assert property ($fell(calibration_running) |->
    run_cnt >= CAL_CYCLES - 1 && run_cnt <= CAL_CYCLES + 1) else $error("run length wrong");
  a_pd_excl: assert property (powered_down |-> !calibration_running)
    else $error("calibrating while down");
  a_pd_after_cal: assert property (power_down_input [*4] ##0 s_cal_end |->
    ##[0:4] powered_down) else $error("no power-down after run");
  a_clk_stop: assert property (internal_clock_stop |->
    calibration_running || $past(calibration_running)) else $error("clock stop outside run");
  a_capture_gate: assert property ($rose(capture_write) |->
    $past(write_enable_pin, 2) && $past(write_enable_pin, 3)) else $error("capture too early");
endmodule // cal_ctrl_asserts
bind cal_ctrl cal_ctrl_asserts #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.*);
`default_nettype wire

// ==== testbench/cal_host_model.sv ====
// Host model that produces the calibration request pin sequence.
// Assumes go is a one-cycle pulse on mclk; park is the idle pin level.
`timescale 1ns/1ps
`default_nettype none
module cal_host_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic park,
  input wire logic [7:0] low_len,
  output logic cal_req,
  output logic busy
);
  int cnt = 0; // Position inside the command
  initial busy = 1'b0;
  // Low phase of low_len cycles, then a full 80-cycle high phase
  always @(posedge mclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      cnt <= 0;
    end else if (busy) begin
      cnt <= cnt + 1;
      if (cnt == low_len + 79) busy <= 1'b0;
    end
  end
  // Short low phases are allowed so the device's refusal can be seen
  assign cal_req = busy ? (cnt >= low_len) : park;
endmodule // cal_host_model
`default_nettype wire

// ==== testbench/test_adc_calibration_control.sv ====
// Self-checking bench for the calibration control block.
// Assumes the block's header and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "cal_ctrl_defs.vh"
module test_adc_calibration_control;
  localparam [15:0] CAL_N = 16'h0010; // Shortened run length
  logic mclk = 0, rst_n = 0, go = 0, park = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, power_down_input = 0, cal_delay_select = 0, write_enable_pin = 0;
  logic full_scale_select = 0, output_edge_rate_select = 0, extended_mode_pin = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [8:0] rise_sample = 0, fall_sample = 0;
  logic [7:0] low_len = 8'h50;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, host_busy;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire cal_request_pin, calibration_running, out_of_range, capture_write, powered_down;
  wire internal_clock_stop, full_scale_eff, output_edge_eff;
  wire [7:0] data_rise, data_fall;
  int errors = 0, check_count = 0;
  logic [33:0] exp_q[$], mask_q[$]; // Expected bus answers, oldest first
  always #10 mclk = ~mclk;
  cal_ctrl #(.DLY_SHORT(32'h0000_0040), .DLY_LONG(32'h0000_0080), .CAL_CYCLES(CAL_N)) u_dut (.*);
  cal_host_model u_host (.mclk(mclk), .go(go), .park(park), .low_len(low_len),
    .cal_req(cal_request_pin), .busy(host_busy));
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watches the answer channels and compares with the oldest note
  always @(posedge mclk) begin
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
      check((s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0}) & mask_q[0],
        exp_q[0]);
      void'(exp_q.pop_front());
      void'(mask_q.pop_front());
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Register traffic only between runs, never during one
  task automatic axi_rd(input logic [3:0] a, input logic [33:0] e, input logic [33:0] m);
    int n;
    exp_q.push_back(e);
    mask_q.push_back(m);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100 && !s_axi_rvalid; n++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (n >= 100) errors++; // Read answer never came
    s_axi_rready <= 1'b0;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    exp_q.push_back({`RESP_OKAY, 32'h0});
    mask_q.push_back({2'h3, 32'h0});
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 100 && !s_axi_bvalid; n++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    if (n >= 100) errors++; // Write response never came
    s_axi_bready <= 1'b0;
  endtask
  task automatic wait_cal(input int lim, output int n);
    for (n = 0; n < lim && !calibration_running; n++) @(posedge mclk);
  endtask
  task automatic run_len(output int n);
    for (n = 0; n < 100 && calibration_running; n++) @(posedge mclk);
  endtask
  task automatic host_cmd(input logic [7:0] len);
    @(posedge mclk);
    low_len <= len;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    tick(2);
    while (host_busy) @(posedge mclk);
  endtask
  task automatic do_reset(input logic req, input logic pd, input logic dly);
    @(posedge mclk);
    {rst_n, park, power_down_input, cal_delay_select} <= {1'b0, req, pd, dly};
    tick(20);
    rst_n <= 1'b1;
  endtask
  function automatic logic [7:0] clampf(input logic [8:0] s);
    return s[8] ? (s[7] ? 8'h00 : 8'hff) : s[7:0];
  endfunction
  // Main sequence
  initial begin
    int n;
    logic [8:0] r, f;
    void'($urandom(32'h34b8));
    do_reset(1'b0, 1'b0, 1'b0);
    wait_cal(200, n);
    check({33'h0, n >= 60 && n <= 76}, 34'h1);
    run_len(n);
    check({33'h0, n >= CAL_N - 1 && n <= CAL_N + 1}, 34'h1);
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      f = $urandom;
      rise_sample <= r;
      fall_sample <= f;
      tick(3);
      check({out_of_range, data_rise, data_fall}, {r[8] | f[8], clampf(r), clampf(f)});
    end
    axi_wr(`OFF_CTRL, 32'h0000_0020);
    axi_rd(`OFF_CTRL, {`RESP_OKAY, 32'h20}, {2'h3, 32'h1ff});
    axi_rd(4'h2, {`RESP_SLVERR, 32'h0}, {2'h3, 32'h0});
    axi_rd(`OFF_STAT, {2'h0, 32'h0001_0001}, {2'h3, 32'hffff_001b});
    park <= 1'b1; // Pin low since reset, now high: a full command
    wait_cal(120, n);
    check({33'h0, n >= 78 && n <= 92}, 34'h1);
    tick(4);
    check({33'h0, internal_clock_stop}, 34'h1);
    run_len(n);
    host_cmd(8'h28);
    tick(10);
    check({33'h0, calibration_running}, 34'h0);
    axi_wr(`OFF_CTRL, 32'h0000_0060); // Trim disabled before the command
    host_cmd(8'h50);
    wait_cal(10, n);
    check({33'h0, n < 10}, 34'h1);
    check({33'h0, internal_clock_stop}, 34'h0);
    run_len(n);
    write_enable_pin <= 1'b1;
    for (n = 0; n < 20 && !capture_write; n++) @(posedge mclk);
    check({33'h0, n >= 3 && n <= 10}, 34'h1);
    {write_enable_pin, full_scale_select, output_edge_rate_select} <= 3'h3;
    tick(6);
    check({32'h0, full_scale_eff, output_edge_eff}, 34'h3);
    power_down_input <= 1'b1;
    tick(6);
    check({33'h0, powered_down}, 34'h1);
    host_cmd(8'h50);
    tick(20);
    check({33'h0, calibration_running}, 34'h0);
    power_down_input <= 1'b0;
    tick(6);
    host_cmd(8'h50); // New run after the range change
    wait_cal(10, n);
    power_down_input <= 1'b1;
    run_len(n);
    check({33'h0, n >= CAL_N - 2 && n <= CAL_N + 1}, 34'h1);
    tick(6);
    check({33'h0, powered_down}, 34'h1);
    do_reset(1'b0, 1'b1, 1'b1);
    tick(100);
    power_down_input <= 1'b0;
    wait_cal(300, n);
    check({33'h0, n >= 126 && n <= 140}, 34'h1);
    do_reset(1'b1, 1'b0, 1'b0);
    wait_cal(200, n);
    check(n, 200);
    end_of_test;
  end
  // Watchdog, far beyond the roughly 1500 cycles the sequence needs
  initial begin
    tick(20000);
    errors++;
    end_of_test;
  end
endmodule // test_adc_calibration_control
`default_nettype wire
